// ===== rtl/tsc_traction_cmd.sv
// command station side: stop/power command decoder and consist error sender
`timescale 1ns/1ns
`default_nettype none

module tsc_traction_cmd
    import tsc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic rev3_mode,
    input wire logic poll_start,
    input wire logic poll_is_ack,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic consist_fail,
    input wire logic [3:0] error_code4,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic poll_hold,
    output logic ack_retry,
    output logic track_on,
    output logic estop_all,
    output logic stop_all,
    output logic stop_loco,
    output logic [13:0] stop_addr,
    output logic bc_all_on,
    output logic bc_all_off
);

    typedef struct packed {
        tsc_rx_e rx_st;
        tsc_tx_e tx_st;
        logic cmd_open;
        logic [7:0] hdr;
        logic [7:0] chk;
        logic [3:0] cnt;
        logic [3:0] idx;
        logic [MAX_DATA-1:0][7:0] data;
        logic err_new;
        logic [7:0] err_data;
        logic tx_valid;
        logic [7:0] tx_byte;
        logic poll_hold;
        logic ack_retry;
        logic track_on;
        logic estop_all;
        logic on_pend;
        logic stop_all;
        logic stop_loco;
        logic [13:0] stop_addr;
        logic bc_all_on;
        logic bc_all_off;
    } tsc_state_s;

    tsc_state_s s;
    tsc_state_s next_s;
    logic [13:0] long_addr;
    logic [3:0] code3;
    logic rx_take;

    assign long_addr = {s.data[0][5:0], s.data[1]};
    assign code3 = error_code4 + CODE3_OFFSET;
    // a byte that the open turn will take; a poll in the same cycle wins
    assign rx_take = rx_valid && s.cmd_open && !poll_start;

    always_comb begin
        next_s = s;
        next_s.stop_all = 1'b0;
        next_s.stop_loco = 1'b0;
        next_s.bc_all_on = 1'b0;
        next_s.bc_all_off = 1'b0;

        // a fresh poll abandons any half message and opens one turn
        if (poll_start) begin
            next_s.cmd_open = 1'b1;
            if (next_s.rx_st != RX_WALK) begin
                next_s.rx_st = RX_HDR;
            end
            if (poll_is_ack) begin
                next_s.ack_retry = 1'b1;
            end
        end else if (rx_valid && s.cmd_open) begin
            unique case (s.rx_st)
                RX_HDR: begin
                    next_s.hdr = rx_byte;
                    next_s.chk = rx_byte;
                    next_s.cnt = rx_byte[3:0];
                    next_s.idx = 4'h0;
                    next_s.rx_st = (rx_byte[3:0] == 4'h0) ? RX_CHK : RX_DATA;
                end
                RX_DATA: begin
                    next_s.data[s.idx] = rx_byte;
                    next_s.chk = s.chk ^ rx_byte;
                    next_s.idx = s.idx + 4'h1;
                    if (s.idx == s.cnt - 4'h1) begin
                        next_s.rx_st = RX_CHK;
                    end
                end
                RX_CHK: begin
                    // the turn is used up even by a corrupted message
                    next_s.cmd_open = 1'b0;
                    next_s.rx_st = RX_HDR;
                    if (rx_byte == s.chk) begin
                        if (s.hdr == HDR_ACK) begin
                            next_s.ack_retry = 1'b0;
                        end else if (s.hdr == HDR_POWER && s.data[0] == PWR_ON_DATA) begin
                            next_s.track_on = 1'b1;
                            next_s.estop_all = 1'b0;
                            next_s.on_pend = 1'b1;
                        end else if (s.hdr == HDR_POWER && s.data[0] == PWR_OFF_DATA) begin
                            next_s.track_on = 1'b0;
                            next_s.bc_all_off = 1'b1;
                        end else if (s.hdr == HDR_STOP_ALL) begin
                            next_s.estop_all = 1'b1;
                            next_s.stop_all = 1'b1;
                        end else if (s.hdr == HDR_STOP1_NEW && rev3_mode) begin
                            if (long_addr <= MAX_LONG_ADDR) begin
                                next_s.stop_loco = 1'b1;
                                next_s.stop_addr = long_addr;
                            end
                        end else if (s.hdr == HDR_STOP1_OLD) begin
                            if (s.data[0] <= MAX_SHORT_ADDR) begin
                                next_s.stop_loco = 1'b1;
                                next_s.stop_addr = {6'h00, s.data[0]};
                            end
                        end else if (s.hdr[7:4] == HDR_MSTOP_HI && s.cnt != 4'h0
                                     && !rev3_mode) begin
                            next_s.idx = 4'h0;
                            next_s.rx_st = RX_WALK;
                        end
                    end
                end
                RX_WALK: begin
                end
                default: begin
                    next_s.rx_st = RX_HDR;
                end
            endcase
        end

        // multi stop: one locomotive per cycle, out-of-range ones skipped
        if (s.rx_st == RX_WALK) begin
            if (s.data[s.idx] <= MAX_SHORT_ADDR) begin
                next_s.stop_loco = 1'b1;
                next_s.stop_addr = {6'h00, s.data[s.idx]};
            end
            next_s.idx = s.idx + 4'h1;
            if (s.idx == s.cnt - 4'h1) begin
                next_s.rx_st = RX_HDR;
            end
        end

        // broadcast follows the restored voltage by one cycle
        if (s.on_pend && s.track_on) begin
            next_s.on_pend = 1'b0;
            next_s.bc_all_on = 1'b1;
        end

        // error reply: a second failure while one is in flight is dropped
        unique case (s.tx_st)
            TX_IDLE: begin
                if (consist_fail) begin
                    next_s.err_new = rev3_mode;
                    if (rev3_mode && error_code4 >= ERR4_NOT_HELD
                        && error_code4 <= ERR4_ADDR_IN_USE) begin
                        next_s.err_data = ERR_ID_BASE | {4'h0, error_code4};
                        next_s.tx_byte = HDR_ERR_NEW;
                        next_s.tx_valid = 1'b1;
                        next_s.poll_hold = 1'b1;
                        next_s.tx_st = TX_HDR;
                    end else if (!rev3_mode && error_code4 >= ERR4_NOT_HELD
                                 && error_code4 <= ERR4_SPEED) begin
                        next_s.err_data = ERR_ID_BASE | {5'h00, code3[2:0]};
                        next_s.tx_byte = HDR_ERR_OLD;
                        next_s.tx_valid = 1'b1;
                        next_s.poll_hold = 1'b1;
                        next_s.tx_st = TX_HDR;
                    end
                end
            end
            TX_HDR: begin
                if (tx_ready) begin
                    next_s.tx_byte = s.err_data;
                    next_s.tx_st = TX_DAT;
                end
            end
            TX_DAT: begin
                if (tx_ready) begin
                    next_s.tx_byte = (s.err_new ? HDR_ERR_NEW : HDR_ERR_OLD) ^ s.err_data;
                    next_s.tx_st = TX_CHK;
                end
            end
            TX_CHK: begin
                if (tx_ready) begin
                    next_s.tx_valid = 1'b0;
                    next_s.poll_hold = 1'b0;
                    next_s.tx_byte = 8'h00;
                    next_s.tx_st = TX_IDLE;
                end
            end
            default: begin
                next_s.tx_st = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= '0;
            s.rx_st <= RX_HDR;
            s.tx_st <= TX_IDLE;
            s.track_on <= RST_TRACK_ON;
            s.estop_all <= RST_ESTOP;
        end else begin
            s <= next_s;
        end
    end

    // every output is a field of the registered state
    assign tx_valid = s.tx_valid;
    assign tx_byte = s.tx_byte;
    assign poll_hold = s.poll_hold;
    assign ack_retry = s.ack_retry;
    assign track_on = s.track_on;
    assign estop_all = s.estop_all;
    assign stop_all = s.stop_all;
    assign stop_loco = s.stop_loco;
    assign stop_addr = s.stop_addr;
    assign bc_all_on = s.bc_all_on;
    assign bc_all_off = s.bc_all_off;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_OLD_ERR_FRAME: assert property (
        (s.tx_st == TX_IDLE && consist_fail && !rev3_mode && error_code4 == ERR4_SPEED)
        |=> tx_valid && tx_byte == HDR_ERR_OLD && s.err_data == 8'h86)
        else $error("old consist error frame wrong");
    AST_OLD_CODE_MAP: assert property (
        (s.tx_st == TX_IDLE && consist_fail && !rev3_mode && error_code4 == ERR4_NOT_HELD)
        |=> s.err_data == 8'h83)
        else $error("old error code not 011");
    AST_TX_ONLY_ON_FAIL: assert property (
        $rose(tx_valid) |-> $past(consist_fail))
        else $error("reply sent without a failure");
    AST_HOLD_DURING_REPLY: assert property (
        tx_valid |-> poll_hold)
        else $error("poll allowed during error reply");
    // the sink may stall, so byte order is checked per handshake, not per cycle
    AST_NEW_ERR_BYTES: assert property (
        (s.tx_st == TX_IDLE && consist_fail && rev3_mode && error_code4 == ERR4_ADDR_IN_USE)
        |=> tx_valid && tx_byte == HDR_ERR_NEW && s.err_data == 8'h8A)
        else $error("new error reply bytes wrong");
    AST_ERR_DATA_NEXT: assert property (
        (s.tx_st == TX_HDR && tx_ready && s.err_data == 8'h8A) |=> tx_byte == 8'h8A)
        else $error("error identifier byte not sent after header");
    AST_ERR_CHK_NEXT: assert property (
        (s.tx_st == TX_DAT && tx_ready && s.err_new && s.err_data == 8'h8A)
        |=> tx_byte == 8'h6B)
        else $error("new error check byte wrong");
    AST_OLD_CHK_NEXT: assert property (
        (s.tx_st == TX_DAT && tx_ready && !s.err_new && s.err_data == 8'h86)
        |=> tx_byte == 8'hE7)
        else $error("old error check byte wrong");
    AST_ONE_CMD_PER_POLL: assert property (
        (s.rx_st == RX_CHK && rx_valid && s.cmd_open && !poll_start) |=> !s.cmd_open)
        else $error("second command allowed in one turn");
    AST_ACK_REPEAT: assert property (
        (poll_start && poll_is_ack) |=> ack_retry)
        else $error("ack retry not armed");
    AST_ALL_ON_BC: assert property (
        $rose(track_on) |-> ##1 bc_all_on)
        else $error("no all-on broadcast after power-on");
    AST_ALL_OFF_BC: assert property (
        $fell(track_on) |-> bc_all_off)
        else $error("no all-off broadcast with power-off");
    AST_STOP_ALL_KEEPS_POWER: assert property (
        stop_all |-> estop_all && track_on == $past(track_on))
        else $error("stop-all disturbed track power");
    AST_STOP_RANGE: assert property (
        stop_loco |-> stop_addr <= MAX_LONG_ADDR)
        else $error("stop address out of range");
    AST_NEW_CODE_MAP: assert property (
        (s.tx_st == TX_IDLE && consist_fail && rev3_mode && error_code4 == ERR4_NOT_HELD)
        |=> s.err_data == 8'h81)
        else $error("new error code 0001 not sent");
    AST_NEW_STACK_FULL: assert property (
        (s.tx_st == TX_IDLE && consist_fail && rev3_mode && error_code4 == ERR4_STACK_FULL)
        |=> s.err_data == 8'h88)
        else $error("new error code 1000 not sent");
    AST_NO_REPLY_BAD_CODE: assert property (
        (s.tx_st == TX_IDLE && consist_fail && !rev3_mode && error_code4 > ERR4_SPEED)
        |=> !tx_valid)
        else $error("old form reply for a code it cannot carry");
    AST_POWER_ON: assert property (
        (s.rx_st == RX_CHK && rx_take && rx_byte == s.chk && s.hdr == HDR_POWER
         && s.data[0] == PWR_ON_DATA) |=> track_on && !estop_all)
        else $error("power-on command did not restore track");
    AST_POWER_OFF: assert property (
        (s.rx_st == RX_CHK && rx_take && rx_byte == s.chk && s.hdr == HDR_POWER
         && s.data[0] == PWR_OFF_DATA) |=> !track_on)
        else $error("power-off command left track on");
    AST_OLD_STOP_RANGE: assert property (
        (s.rx_st == RX_CHK && rx_take && s.hdr == HDR_STOP1_OLD
         && s.data[0] > MAX_SHORT_ADDR) |=> !stop_loco)
        else $error("single stop accepted an address above 99");
    AST_WALK_RANGE: assert property (
        (s.rx_st == RX_WALK) |=> !stop_loco || stop_addr <= 14'(MAX_SHORT_ADDR))
        else $error("multi stop passed an address above 99");
    AST_BAD_CHK_DROPPED: assert property (
        (s.rx_st == RX_CHK && rx_take && rx_byte != s.chk)
        |=> !stop_loco && !stop_all && !bc_all_off && $stable(track_on))
        else $error("message with a bad check byte acted on");
    AST_MULTI_DROPPED_REV3: assert property (
        (s.rx_st == RX_CHK && rx_take && rev3_mode && s.hdr == {HDR_MSTOP_HI, 4'h3})
        |=> s.rx_st == RX_HDR)
        else $error("multi stop walked in revision 3 mode");
    AST_HDR_COUNT: assert property (
        (s.rx_st == RX_HDR && rx_take && rx_byte[3:0] == 4'h0) |=> s.rx_st == RX_CHK)
        else $error("header without data did not go to check byte");

endmodule

`default_nettype wire

// ===== include/tsc_pkg.sv
// constants and types for the traction stop and consist error block
package tsc_pkg;
    // command headers and power data bytes taken from a polled device
    localparam logic [7:0] HDR_ACK = 8'h20;
    localparam logic [7:0] HDR_POWER = 8'h21;
    localparam logic [7:0] PWR_ON_DATA = 8'h81;
    localparam logic [7:0] PWR_OFF_DATA = 8'h80;
    localparam logic [7:0] HDR_STOP_ALL = 8'h80;
    localparam logic [7:0] HDR_STOP1_OLD = 8'h91;
    localparam logic [7:0] HDR_STOP1_NEW = 8'h92;
    localparam logic [3:0] HDR_MSTOP_HI = 4'h9;
    // consist error responses
    localparam logic [7:0] HDR_ERR_OLD = 8'h61;
    localparam logic [7:0] HDR_ERR_NEW = 8'hE1;
    localparam logic [7:0] ERR_ID_BASE = 8'h80;
    localparam logic [3:0] CODE3_OFFSET = 4'h2;
    localparam logic [3:0] ERR4_NOT_HELD = 4'h1;
    localparam logic [3:0] ERR4_HELD_ELSEWHERE = 4'h2;
    localparam logic [3:0] ERR4_IN_OTHER = 4'h3;
    localparam logic [3:0] ERR4_SPEED = 4'h4;
    localparam logic [3:0] ERR4_NOT_MULTI = 4'h5;
    localparam logic [3:0] ERR4_NOT_BASE = 4'h6;
    localparam logic [3:0] ERR4_NO_DELETE = 4'h7;
    localparam logic [3:0] ERR4_STACK_FULL = 4'h8;
    localparam logic [3:0] ERR4_NOT_FOUND = 4'h9;
    localparam logic [3:0] ERR4_ADDR_IN_USE = 4'hA;
    // locomotive address limits and message data length
    localparam logic [7:0] MAX_SHORT_ADDR = 8'h63;
    localparam logic [13:0] MAX_LONG_ADDR = 14'h270F;
    localparam int MAX_DATA = 15;
    // reset values
    localparam logic RST_TRACK_ON = 1'b1;
    localparam logic RST_ESTOP = 1'b0;

    typedef enum logic [3:0] {
        RX_HDR = 4'b0001,
        RX_DATA = 4'b0010,
        RX_CHK = 4'b0100,
        RX_WALK = 4'b1000
    } tsc_rx_e;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_HDR = 4'b0010,
        TX_DAT = 4'b0100,
        TX_CHK = 4'b1000
    } tsc_tx_e;
endpackage

// ===== dv/tsc_dev_model.sv
// polled device model: sends queued command bytes and takes error replies
`timescale 1ns/1ns
`default_nettype none

module tsc_dev_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic tx_ready
);
    logic [7:0] msg_q[$];
    logic [7:0] got_q[$];
    logic [7:0] last_byte;
    logic [7:0] b;
    int tick;

    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'hFF;
        tx_ready = 1'b0;
        last_byte = 8'h00;
        tick = 0;
    end

    always @(posedge mclk) begin
        tick <= tick + 1;
        // when slow, the sink stalls every other cycle so reply bytes must hold
        tx_ready <= rst_b && (!slow || tick[0]);
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got_q.push_back(tx_byte);
        end
        if (rst_b && msg_q.size() > 0 && (!slow || tick[0])) begin
            b = msg_q.pop_front();
            rx_valid <= 1'b1;
            rx_byte <= b;
            last_byte <= b;
        end else begin
            // idle line shows no stale byte
            rx_valid <= 1'b0;
            rx_byte <= ~last_byte;
        end
    end
endmodule

`default_nettype wire

// ===== dv/test_traction_error_and_stop_commands.sv
// self-checking bench for the stop command decoder and consist error sender
`timescale 1ns/1ns
`default_nettype none

module test_traction_error_and_stop_commands;
    logic mclk, rst_b, rev3_mode, poll_start, poll_is_ack, consist_fail, slow;
    logic [3:0] error_code4;
    wire logic rx_valid, tx_ready, tx_valid, poll_hold, ack_retry, track_on;
    wire logic estop_all, stop_all, stop_loco, bc_all_on, bc_all_off;
    wire logic [7:0] rx_byte, tx_byte;
    wire logic [13:0] stop_addr;
    logic [7:0] tx_q[$];
    logic [13:0] addr_q[$];
    int n_all, n_on, n_off, cyc, err_count, samples_checked;

    tsc_traction_cmd i_tsc_traction_cmd (.mclk(mclk), .rst_b(rst_b), .rev3_mode(rev3_mode),
        .poll_start(poll_start), .poll_is_ack(poll_is_ack), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .consist_fail(consist_fail), .error_code4(error_code4),
        .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte), .poll_hold(poll_hold),
        .ack_retry(ack_retry), .track_on(track_on), .estop_all(estop_all),
        .stop_all(stop_all), .stop_loco(stop_loco), .stop_addr(stop_addr),
        .bc_all_on(bc_all_on), .bc_all_off(bc_all_off));

    tsc_dev_model i_tsc_dev_model (.mclk(mclk), .rst_b(rst_b), .slow(slow),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_ready(tx_ready));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task close_out;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // pulses are counted here since they stand for one cycle only
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (stop_loco === 1'b1) addr_q.push_back(stop_addr);
        if (stop_all === 1'b1) n_all++;
        if (bc_all_on === 1'b1) n_on++;
        if (bc_all_off === 1'b1) n_off++;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one turn: optional poll, then tx_q plus its check byte
    task turn(input logic ack, input logic bad, input logic no_poll);
        logic [7:0] x;
        x = 8'h00;
        if (!no_poll) begin
            @(posedge mclk);
            poll_start <= 1'b1;
            poll_is_ack <= ack;
            @(posedge mclk);
            poll_start <= 1'b0;
        end
        foreach (tx_q[i]) begin
            x = x ^ tx_q[i];
            i_tsc_dev_model.msg_q.push_back(tx_q[i]);
        end
        if (tx_q.size() > 0) i_tsc_dev_model.msg_q.push_back(x ^ {7'h00, bad});
        for (int k = 0; k < 40 && i_tsc_dev_model.msg_q.size() > 0; k++) @(posedge mclk);
        repeat (8) @(posedge mclk);
        #1;
    endtask

    task t_reset;
        chk("track_on", 16'h1, 16'(track_on));
        chk("idle", 16'h0, 16'({tx_valid, poll_hold, ack_retry, estop_all}));
    endtask

    task t_power;
        tx_q = '{8'h80};
        turn(1'b0, 1'b0, 1'b0);
        chk("stop_all count", 16'h1, 16'(n_all));
        chk("estop and track", 16'h3, 16'({estop_all, track_on}));
        tx_q = '{8'h21, 8'h80};
        turn(1'b0, 1'b0, 1'b0);
        chk("track off", 16'h0, 16'(track_on));
        chk("all off count", 16'h1, 16'(n_off));
        tx_q = '{8'h21, 8'h81};
        turn(1'b0, 1'b0, 1'b0);
        chk("on and estop", 16'h2, 16'({track_on, estop_all}));
        chk("all on count", 16'h1, 16'(n_on));
    endtask

    task t_stops;
        logic [13:0] ea [5];
        ea = '{14'd99, 14'd5, 14'd77, 14'd9999, 14'd7};
        slow <= 1'b1;
        addr_q.delete();
        tx_q = '{8'h91, 8'd99};
        turn(1'b0, 1'b0, 1'b0);
        tx_q = '{8'h91, 8'd100};
        turn(1'b0, 1'b0, 1'b0);
        tx_q = '{8'h91, 8'd5};
        turn(1'b0, 1'b1, 1'b0);
        tx_q = '{8'h93, 8'd5, 8'd120, 8'd77};
        turn(1'b0, 1'b0, 1'b0);
        rev3_mode <= 1'b1;
        tx_q = '{8'h92, 8'h27, 8'h0F};
        turn(1'b0, 1'b0, 1'b0);
        tx_q = '{8'h92, 8'h27, 8'h10};
        turn(1'b0, 1'b0, 1'b0);
        tx_q = '{8'h93, 8'd1, 8'd2, 8'd3};
        turn(1'b0, 1'b0, 1'b0);
        tx_q = '{8'h91, 8'd7};
        turn(1'b0, 1'b0, 1'b0);
        tx_q = '{8'h91, 8'd8};
        turn(1'b0, 1'b0, 1'b1);
        chk("stop count", 16'h5, 16'(addr_q.size()));
        for (int i = 0; i < 5 && i < addr_q.size(); i++) begin
            chk("stop addr", 16'(ea[i]), 16'(addr_q[i]));
        end
        chk("others run", 16'h3, 16'({n_all[0], track_on}));
    endtask

    task t_ack;
        tx_q.delete();
        turn(1'b1, 1'b0, 1'b0);
        chk("ack pending", 16'h1, 16'(ack_retry));
        tx_q = '{8'h20};
        turn(1'b1, 1'b1, 1'b0);
        chk("ack bad answer", 16'h1, 16'(ack_retry));
        turn(1'b1, 1'b0, 1'b0);
        chk("ack answered", 16'h0, 16'(ack_retry));
    endtask

    task err_case(input logic rev3, input logic [3:0] code, input logic reply);
        logic [7:0] d;
        logic [7:0] h;
        h = rev3 ? 8'hE1 : 8'h61;
        d = rev3 ? {4'h8, code} : {5'b10000, 3'(code + 4'd2)};
        i_tsc_dev_model.got_q.delete();
        @(posedge mclk);
        rev3_mode <= rev3;
        consist_fail <= 1'b1;
        error_code4 <= code;
        @(posedge mclk);
        consist_fail <= 1'b0;
        @(posedge mclk);
        #1;
        chk("poll_hold", 16'(reply), 16'(poll_hold));
        repeat (12) @(posedge mclk);
        #1;
        chk("reply len", reply ? 16'h3 : 16'h0, 16'(i_tsc_dev_model.got_q.size()));
        if (reply && i_tsc_dev_model.got_q.size() == 3) begin
            chk("err hdr", 16'(h), 16'(i_tsc_dev_model.got_q[0]));
            chk("err data", 16'(d), 16'(i_tsc_dev_model.got_q[1]));
            chk("err chk", 16'(h ^ d), 16'(i_tsc_dev_model.got_q[2]));
        end
        chk("hold freed", 16'h0, 16'(poll_hold));
    endtask

    initial begin
        rst_b = 1'b0;
        rev3_mode = 1'b0;
        poll_start = 1'b0;
        poll_is_ack = 1'b0;
        consist_fail = 1'b0;
        error_code4 = 4'h0;
        slow = 1'b0;
        {n_all, n_on, n_off, cyc, err_count, samples_checked} = '0;
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        t_reset();
        t_power();
        t_stops();
        t_ack();
        for (int c = 1; c <= 5; c++) err_case(1'b0, 4'(c), c < 5);
        for (int c = 1; c <= 10; c++) err_case(1'b1, 4'(c), 1'b1);
        close_out();
    end
endmodule

`default_nettype wire
